// ==== verilog/bpw_pkg.sv ====
// Purpose: Shared constants for the prefetchable and I/O window register bank
// Assumes: 32-bit register port, byte offsets as printed
// Notes: Low I/O nibbles live here as plain ports, their register is elsewhere
package bpw_pkg;
  // Register byte offsets
  localparam logic [7:0] BPW_OFF_PF_LOW = 8'h24;
  localparam logic [7:0] BPW_OFF_PF_BASE_HI = 8'h28;
  localparam logic [7:0] BPW_OFF_PF_LIMIT_HI = 8'h2C;
  localparam logic [7:0] BPW_OFF_IO_HI = 8'h30;
  // Field positions in the low prefetch register
  localparam int BPW_TOP_LSB = 20;
  localparam int BPW_BOT_LSB = 4;
  localparam int BPW_TOP_CAP_LSB = 16;
  localparam int BPW_BOT_CAP_LSB = 0;
  // Read-only capability value, 64-bit addressing
  localparam logic [3:0] BPW_CAP_64 = 4'h1;
  // Reset values
  localparam logic [31:0] BPW_RST_PF_LOW = 32'h00010001;
  localparam logic [31:0] BPW_RST_WORD = 32'h00000000;
  // Implied low address bits
  localparam logic [19:0] BPW_PF_TOP_FILL = 20'hFFFFF;
  localparam logic [19:0] BPW_PF_BOT_FILL = 20'h00000;
  localparam logic [11:0] BPW_IO_TOP_FILL = 12'hFFF;
  localparam logic [11:0] BPW_IO_BOT_FILL = 12'h000;
endpackage : bpw_pkg

// ==== verilog/bpw_range_chk.sv ====
// Purpose: Inclusive range compare of an address against a window
// Assumes: Bottom and top already assembled
// Notes: Empty window when bottom is above top, so nothing matches
module bpw_range_chk #(
  parameter int W = 64
) (
  input wire logic [W-1:0] addr_i,
  input wire logic [W-1:0] bottom_i,
  input wire logic [W-1:0] top_i,
  output logic hit_o
);
  // Both ends count as inside
  assign hit_o = (addr_i >= bottom_i) && (addr_i <= top_i);
endmodule : bpw_range_chk

// ==== verilog/bpw_window_regs.sv ====
// Purpose: Prefetchable memory window and upper I/O window registers with decode
// Assumes: Single clock, synchronous active-low reset, plain register port
// Notes: Decode outputs are registered, so a hit shows one cycle after the address
// Function
// (RULE1) Top field bits 31:20, low bits ones
// (RULE2) Bottom field bits 15:4, low bits zero
// (RULE3) Capability nibbles read-only, read 0x1
// (RULE4) Offset 0x028 gives bottom bits 63:32
// (RULE5) Offset 0x02C gives top bits 63:32
// (RULE6) I/O upper bits 31:16 give top
// (RULE7) I/O upper bits 15:0 give bottom
// (RULE8) Low I/O top nibble, low bits ones
// (RULE9) Low I/O bottom nibble, low bits zero
// (RULE10) Forward inside inclusive window, ignore read-only writes
module bpw_window_regs (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [3:0] io_base_low_i,
  input wire logic [3:0] io_window_top_low_i,
  input wire logic [63:0] mem_req_addr_i,
  input wire logic [31:0] io_req_addr_i,
  output logic mem_fwd_o,
  output logic io_fwd_o,
  output logic [63:0] pf_bottom_o,
  output logic [63:0] pf_top_o,
  output logic [31:0] io_bottom_o,
  output logic [31:0] io_top_o
);
  import bpw_pkg::*;

  // Writable fields only; the capability nibbles are not stored
  logic [11:0] window_top_field_ff;
  logic [11:0] bottom_field_ff;
  logic [31:0] base_hi_ff;
  logic [31:0] limit_hi_ff;
  logic [15:0] io_window_top_ff;
  logic [15:0] io_bottom_hi_ff;
  logic [31:0] rdata_ff;
  logic mem_fwd_ff;
  logic io_fwd_ff;
  logic [31:0] nxt_rdata;
  logic mem_hit;
  logic io_hit;

  // Reset image of the low prefetch register, split into its fields
  localparam logic [11:0] RST_TOP = BPW_RST_PF_LOW[31:20];
  localparam logic [11:0] RST_BOT = BPW_RST_PF_LOW[15:4];

  // Write decode helper
  function automatic logic hit_wr(input logic [7:0] a, input logic [7:0] off, input logic w);
    return w && (a == off);
  endfunction : hit_wr

  // Low prefetch register write
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      window_top_field_ff <= RST_TOP;
      bottom_field_ff <= RST_BOT;
    end else if (hit_wr(addr_i, BPW_OFF_PF_LOW, wr_i)) begin
      // (RULE3) capability bits dropped
      // (RULE10) read-only nibbles ignored
      window_top_field_ff <= wdata_i[31:BPW_TOP_LSB];
      bottom_field_ff <= wdata_i[15:BPW_BOT_LSB];
    end
  end

  // Upper words of prefetch window
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      base_hi_ff <= BPW_RST_WORD;
      limit_hi_ff <= BPW_RST_WORD;
    end else begin
      // (RULE4) base upper word
      if (hit_wr(addr_i, BPW_OFF_PF_BASE_HI, wr_i)) begin
        base_hi_ff <= wdata_i;
      end
      // (RULE5) limit upper word
      if (hit_wr(addr_i, BPW_OFF_PF_LIMIT_HI, wr_i)) begin
        limit_hi_ff <= wdata_i;
      end
    end
  end

  // I/O upper halves
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      io_window_top_ff <= BPW_RST_WORD[31:16];
      io_bottom_hi_ff <= BPW_RST_WORD[15:0];
    end else if (hit_wr(addr_i, BPW_OFF_IO_HI, wr_i)) begin
      // (RULE6) top halves
      io_window_top_ff <= wdata_i[31:16];
      // (RULE7) bottom halves
      io_bottom_hi_ff <= wdata_i[15:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    nxt_rdata = 32'h00000000;
    case (addr_i)
      BPW_OFF_PF_LOW: begin
        // (RULE3) constant capability nibbles
        nxt_rdata = {window_top_field_ff, BPW_CAP_64, bottom_field_ff, BPW_CAP_64};
      end
      BPW_OFF_PF_BASE_HI: nxt_rdata = base_hi_ff;
      BPW_OFF_PF_LIMIT_HI: nxt_rdata = limit_hi_ff;
      BPW_OFF_IO_HI: nxt_rdata = {io_window_top_ff, io_bottom_hi_ff};
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_ff <= BPW_RST_WORD;
    end else if (rd_i) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end
  assign rdata_o = rdata_ff;

  // Window assembly
  // (RULE1) top low bits ones
  // (RULE5) top high word joined
  assign pf_top_o = {limit_hi_ff, window_top_field_ff, BPW_PF_TOP_FILL};
  // (RULE2) bottom low bits zero
  // (RULE4) bottom high word joined
  assign pf_bottom_o = {base_hi_ff, bottom_field_ff, BPW_PF_BOT_FILL};
  // (RULE8) I/O top fill ones
  assign io_top_o = {io_window_top_ff, io_window_top_low_i, BPW_IO_TOP_FILL};
  // (RULE9) I/O bottom fill zero
  assign io_bottom_o = {io_bottom_hi_ff, io_base_low_i, BPW_IO_BOT_FILL};

  // Range compares share one module
  bpw_range_chk #(.W(64)) u_mem_chk (
    .addr_i(mem_req_addr_i),
    .bottom_i(pf_bottom_o),
    .top_i(pf_top_o),
    .hit_o(mem_hit)
  );
  bpw_range_chk #(.W(32)) u_io_chk (
    .addr_i(io_req_addr_i),
    .bottom_i(io_bottom_o),
    .top_i(io_top_o),
    .hit_o(io_hit)
  );

  // Registered forward decisions; timing cut after wide compares
  // (RULE10) inclusive forward decode
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      mem_fwd_ff <= 1'b0;
      io_fwd_ff <= 1'b0;
    end else begin
      mem_fwd_ff <= mem_hit;
      io_fwd_ff <= io_hit;
    end
  end
  assign mem_fwd_o = mem_fwd_ff;
  assign io_fwd_o = io_fwd_ff;

  // Register field checks; each write is judged by what the next cycle shows
  // Checks watch only what this block drives; the strobes come from outside
  a_cap_read: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE3
    (rd_i && addr_i == BPW_OFF_PF_LOW) |=> (rdata_o[19:16] == 4'h1 && rdata_o[3:0] == 4'h1))
    else $error("capability nibble not 0x1");
  a_top_fill: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE1
    (wr_i && addr_i == BPW_OFF_PF_LOW) |=> pf_top_o[31:0] == {$past(wdata_i[31:20]), 20'hFFFFF})
    else $error("prefetch top not from write");
  a_bot_fill: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE2
    (wr_i && addr_i == BPW_OFF_PF_LOW) |=> pf_bottom_o[31:0] == {$past(wdata_i[15:4]), 20'h0})
    else $error("prefetch bottom not from write");
  a_base_hi: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE4
    (wr_i && addr_i == BPW_OFF_PF_BASE_HI) |=> pf_bottom_o[63:32] == $past(wdata_i))
    else $error("base upper word not written");
  a_limit_hi: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE5
    (wr_i && addr_i == BPW_OFF_PF_LIMIT_HI) |=> pf_top_o[63:32] == $past(wdata_i))
    else $error("limit upper word not written");
  a_io_top: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE6
    (wr_i && addr_i == BPW_OFF_IO_HI) |=> io_top_o[31:16] == $past(wdata_i[31:16]))
    else $error("I/O top upper half wrong");
  a_io_bot: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE7
    (wr_i && addr_i == BPW_OFF_IO_HI) |=> io_bottom_o[31:16] == $past(wdata_i[15:0]))
    else $error("I/O bottom upper half wrong");

  // Fill checks hold every cycle, since the low nibbles are levels from outside
  a_io_fill: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE8
    io_top_o[11:0] == 12'hFFF && io_top_o[15:12] == io_window_top_low_i)
    else $error("I/O top fill wrong");
  a_io_bfill: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE9
    io_bottom_o[11:0] == 12'h000 && io_bottom_o[15:12] == io_base_low_i)
    else $error("I/O bottom fill wrong");

  // Forward decode checks, both outcomes, so a stuck output cannot pass
  // Compares are written out here rather than reusing the checker's output
  a_mem_fwd: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE10
    (mem_req_addr_i >= pf_bottom_o && mem_req_addr_i <= pf_top_o) |=> mem_fwd_o)
    else $error("memory request inside window not forwarded");
  a_mem_nofwd: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE10
    !(mem_req_addr_i >= pf_bottom_o && mem_req_addr_i <= pf_top_o) |=> !mem_fwd_o)
    else $error("memory request outside window forwarded");
  a_io_fwd: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE10
    (io_req_addr_i >= io_bottom_o && io_req_addr_i <= io_top_o) |=> io_fwd_o)
    else $error("I/O request inside window not forwarded");
  a_io_nofwd: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE10
    !(io_req_addr_i >= io_bottom_o && io_req_addr_i <= io_top_o) |=> !io_fwd_o)
    else $error("I/O request outside window forwarded");

  // Scenario covers
  c_mem_hit: cover property (@(posedge clock_i) disable iff (!rstn_i) mem_fwd_o);
  c_io_hit: cover property (@(posedge clock_i) disable iff (!rstn_i) io_fwd_o);
  // Write then read of the low register
  c_rd_low: cover property (@(posedge clock_i) disable iff (!rstn_i)
    wr_i && addr_i == BPW_OFF_PF_LOW ##1 rd_i && addr_i == BPW_OFF_PF_LOW);
  c_io_wr: cover property (@(posedge clock_i) disable iff (!rstn_i)
    wr_i && addr_i == BPW_OFF_IO_HI);
  // Forward output falls when the address leaves the window
  c_fwd_drop: cover property (@(posedge clock_i) disable iff (!rstn_i)
    mem_fwd_o ##1 !mem_fwd_o);
endmodule : bpw_window_regs

// ==== sim/bpw_req_src.sv ====
// Purpose: Downstream request source standing in for the upstream link
// Assumes: One clock; each address is launched just after a rising edge
// Notes: Holds each address as a level until the bench asks for another
module bpw_req_src (
  input wire logic clock_i,
  input wire logic [63:0] mem_want_i,
  input wire logic [31:0] io_want_i,
  output logic [63:0] mem_addr_o,
  output logic [31:0] io_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Launch one edge after the request, as a real link would
  always_ff @(posedge clock_i) begin
    mem_addr_o <= mem_want_i;
    io_addr_o <= io_want_i;
  end
endmodule : bpw_req_src

// ==== sim/bpw_window_regs_tb.sv ====
// Purpose: Self-checking bench for the window register bank and its decode
// Assumes: Read data one cycle after the strobe; decode one cycle after the address
// Notes: Fixed waits only where the latency is fixed; a watchdog cuts hangs short
module bpw_window_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h00000000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] io_base_low_i = 4'h5;
  logic [3:0] io_window_top_low_i = 4'hA;
  logic [63:0] mem_want = 64'h0;
  logic [31:0] io_want = 32'h0;
  logic [63:0] mem_req_addr, pf_bottom_o, pf_top_o;
  logic [31:0] io_req_addr, rdata_o, io_bottom_o, io_top_o;
  logic mem_fwd_o, io_fwd_o;
  int fails = 0;
  int tests_run = 0;
  bpw_req_src i_bpw_req_src (.clock_i(clock_i), .mem_want_i(mem_want), .io_want_i(io_want),
    .mem_addr_o(mem_req_addr), .io_addr_o(io_req_addr));
  bpw_window_regs i_bpw_window_regs (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .io_base_low_i(io_base_low_i), .io_window_top_low_i(io_window_top_low_i),
    .mem_req_addr_i(mem_req_addr), .io_req_addr_i(io_req_addr), .mem_fwd_o(mem_fwd_o),
    .io_fwd_o(io_fwd_o), .pf_bottom_o(pf_bottom_o), .pf_top_o(pf_top_o),
    .io_bottom_o(io_bottom_o), .io_top_o(io_top_o));
  // Free-running 100 MHz clock
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  // One compare; four-state equality so an unknown never matches
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask : chk
  // One-cycle write strobe, released on the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  // Read data stands only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", {32'h0, rdata_o}, {32'h0, exp});
  endtask : rd
  // Source launches one edge late and decode adds one more
  task automatic probe(input logic [63:0] m, input logic [31:0] io, input logic em, input logic ei);
    @(posedge clock_i);
    mem_want <= m;
    io_want <= io;
    repeat (3) @(posedge clock_i);
    #1;
    chk("mem_fwd", {63'h0, mem_fwd_o}, {63'h0, em});
    chk("io_fwd", {63'h0, io_fwd_o}, {63'h0, ei});
  endtask : probe
  // Verdict in one place
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clock_i);
    fails++;
    results();
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(8'h24, 32'h00010001);
    rd(8'h28, 32'h0);
    rd(8'h2C, 32'h0);
    rd(8'h30, 32'h0);
    chk("top_rst", pf_top_o, 64'h00000000_000FFFFF);
    // Capability nibbles must survive a write of other values
    wr(8'h24, 32'hABC5DEF7);
    rd(8'h24, 32'hABC1DEF1);
    // Read data stands one cycle only, then drops back to zero
    @(posedge clock_i);
    #1;
    chk("rdata_idle", {32'h0, rdata_o}, 64'h0);
    wr(8'h28, 32'h00000001);
    wr(8'h2C, 32'h00000002);
    wr(8'h30, 32'h12340012);
    // Unmapped place takes nothing and reads zero
    wr(8'h34, 32'hFFFFFFFF);
    rd(8'h34, 32'h0);
    rd(8'h28, 32'h00000001);
    rd(8'h2C, 32'h00000002);
    rd(8'h30, 32'h12340012);
    chk("pf_bot", pf_bottom_o, 64'h00000001_DEF00000);
    chk("pf_top", pf_top_o, 64'h00000002_ABCFFFFF);
    chk("io_bot", {32'h0, io_bottom_o}, 64'h00125000);
    chk("io_top", {32'h0, io_top_o}, 64'h1234AFFF);
    // Low nibbles are levels, so the bounds follow them at once
    @(posedge clock_i);
    io_base_low_i <= 4'h4;
    io_window_top_low_i <= 4'hB;
    #1;
    chk("io_bot2", {32'h0, io_bottom_o}, 64'h00124000);
    chk("io_top2", {32'h0, io_top_o}, 64'h1234BFFF);
    // Both ends inclusive, one past each end outside
    probe(64'h00000001_DEF00000, 32'h00124000, 1'b1, 1'b1);
    probe(64'h00000001_DEEFFFFF, 32'h00123FFF, 1'b0, 1'b0);
    probe(64'h00000002_ABCFFFFF, 32'h1234BFFF, 1'b1, 1'b1);
    probe(64'h00000002_ABD00000, 32'h1234C000, 1'b0, 1'b0);
    // A second reset in mid-run restores every register
    @(posedge clock_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(8'h24, 32'h00010001);
    rd(8'h28, 32'h0);
    rd(8'h30, 32'h0);
    chk("top_rst2", pf_top_o, 64'h00000000_000FFFFF);
    results();
  end
endmodule : bpw_window_regs_tb
